// ### logic/opc_otp_host.sv
`timescale 1ns/1ps
// Summary of operation
// R1: erased or new cells read as ones
// R2: programming clears bits; ones stay untouched
// R3: zero never returns to one electrically
// R4: program needs high supply, select, strobe low
// R5: full word driven onto data pins
// R6: address stable 2 us before strobe
// R7: write data valid 2 us before strobe
// R8: select low 2 us before strobe
// R9: data held 2 us after strobe rises
// R10: data released 2 us before gate low
// R11: address changes only with gate high
// R12: device drives data after gate access
// R13: select high floats pins within limit
// R14: gate high floats pins within limit
// R15: pulse then verify until match; code stops after MAX_PULSES pulses or when a wanted one reads as zero
// R16: verify: select, gate low, strobe high
// R17: deselected device ignores strobes
// R18: strobe 95..105 us; supply before strobe
module opc_otp_host import opc_pkg::*; #(
  parameter int PULSE_CYC = PULSE_US * CLK_MHZ
) (
  input wire logic clk,              // 200 MHz clock
  input wire logic rst_b,            // async reset, active low
  input wire logic cmdValid,         // command offered
  output logic cmdReady,             // command taken when both high
  input wire logic cmdWrite,         // 1 program word, 0 read word
  input wire logic [15:0] cmdAddr,   // word address
  input wire logic [15:0] cmdData,   // word to program
  output logic rspValid,             // one-cycle result strobe
  output logic [15:0] rspData,       // word read back
  output logic rspErr,               // program failed
  output logic [7:0] rspPulses,      // pulses used
  output logic [15:0] memAddr,       // address pins
  output logic chipSelB,             // chip select, active low
  output logic outGateB,             // output gate, active low
  output logic progStrobeB,          // program strobe, active low
  output logic vppEn,                // raise programming supply
  input wire logic [15:0] dataPinsIn, // data pins, level seen
  output logic [15:0] dataPinsOut,   // data pins, driven value
  output logic dataPinsOe            // data pins, drive enable
);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic [1:0] rstPipe_r;
  logic rstSyncB;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstPipe_r <= 2'h0;
    end else begin
      rstPipe_r <= {rstPipe_r[0], 1'b1};
    end
  end
  assign rstSyncB = rstPipe_r[1];

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_RD_ACC = 4'h1, ST_RD_GATE = 4'h2,
    ST_RD_FLOAT = 4'h3, ST_PG_SETUP = 4'h4, ST_PG_PULSE = 4'h5,
    ST_PG_HOLD = 4'h6, ST_PG_REL = 4'h7, ST_PG_GATE = 4'h8,
    ST_PG_FLOAT = 4'h9
  } opc_st_e;
  typedef struct packed {
    opc_st_e st;
    opc_data_t syncA, syncB, dataOut, want, rspData;
    opc_addr_t memAddr;
    logic dataOe, chipSelB, outGateB, progStrobeB, vppEn, tmrStart;
    opc_cnt_t tmrLoad;
    opc_pcnt_t pulses;
    logic cmdReady, rspValid, rspErr;
  } opc_state_s;

  localparam opc_state_s RST_STATE = '{st: ST_IDLE, chipSelB: 1'b1,
    outGateB: 1'b1, progStrobeB: 1'b1, default: '0};
  localparam opc_cnt_t PULSE_LEN = opc_cnt_t'(PULSE_CYC);
  opc_state_s s_r, s_nxt;
  opc_tmr_if tif ();

  function automatic opc_cnt_t tload(input opc_cnt_t cyc);
    return cyc - TMR_OVH;
  endfunction

  opc_timer u_timer (
    .clk(clk),
    .rstSyncB(rstSyncB),
    .tif(tif)
  );
  assign tif.start = s_r.tmrStart;
  assign tif.load = s_r.tmrLoad;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.syncA = dataPinsIn;
    s_nxt.syncB = s_r.syncA;
    s_nxt.tmrStart = 1'b0;
    s_nxt.rspValid = 1'b0;
    unique case (s_r.st)
      ST_IDLE: begin
        s_nxt.cmdReady = 1'b1;
        if (cmdValid && s_r.cmdReady) begin
          s_nxt.cmdReady = 1'b0;
          s_nxt.memAddr = cmdAddr;
          s_nxt.want = cmdData;
          s_nxt.pulses = '0;
          s_nxt.chipSelB = 1'b0;       // [R17]
          s_nxt.tmrStart = 1'b1;
          if (cmdWrite) begin
            s_nxt.dataOut = cmdData;   // [R5]
            s_nxt.dataOe = 1'b1;       // [R5]
            s_nxt.vppEn = 1'b1;        // [R18]
            s_nxt.tmrLoad = tload(SETUP_CYC); // [R6] [R7] [R8]
            s_nxt.st = ST_PG_SETUP;
          end else begin
            s_nxt.tmrLoad = tload(ACC_CYC);
            s_nxt.st = ST_RD_ACC;
          end
        end
      end
      ST_RD_ACC: begin
        if (tif.done) begin
          s_nxt.outGateB = 1'b0;
          s_nxt.tmrStart = 1'b1;
          s_nxt.tmrLoad = tload(GATE_CYC); // [R12]
          s_nxt.st = ST_RD_GATE;
        end
      end
      ST_RD_GATE: begin
        if (tif.done) begin
          s_nxt.rspData = s_r.syncB;
          s_nxt.outGateB = 1'b1;
          s_nxt.chipSelB = 1'b1;
          s_nxt.tmrStart = 1'b1;
          s_nxt.tmrLoad = tload(FLOAT_CYC); // [R13] [R14]
          s_nxt.st = ST_RD_FLOAT;
        end
      end
      ST_RD_FLOAT: begin
        if (tif.done) begin
          s_nxt.rspValid = 1'b1;
          s_nxt.rspErr = 1'b0;
          s_nxt.st = ST_IDLE;
        end
      end
      ST_PG_SETUP: begin
        if (tif.done) begin
          s_nxt.progStrobeB = 1'b0;      // [R4]
          s_nxt.pulses = s_r.pulses + 8'h01;
          s_nxt.tmrStart = 1'b1;
          s_nxt.tmrLoad = tload(PULSE_LEN); // [R18]
          s_nxt.st = ST_PG_PULSE;
        end
      end
      ST_PG_PULSE: begin
        if (tif.done) begin
          s_nxt.progStrobeB = 1'b1;
          s_nxt.tmrStart = 1'b1;
          s_nxt.tmrLoad = tload(HOLD_CYC); // [R9]
          s_nxt.st = ST_PG_HOLD;
        end
      end
      ST_PG_HOLD: begin
        if (tif.done) begin
          s_nxt.dataOe = 1'b0;
          s_nxt.tmrStart = 1'b1;
          s_nxt.tmrLoad = tload(OE_SETUP_CYC); // [R10]
          s_nxt.st = ST_PG_REL;
        end
      end
      ST_PG_REL: begin
        if (tif.done) begin
          s_nxt.outGateB = 1'b0;         // [R16]
          s_nxt.tmrStart = 1'b1;
          s_nxt.tmrLoad = tload(GATE_CYC);
          s_nxt.st = ST_PG_GATE;
        end
      end
      ST_PG_GATE: begin
        if (tif.done) begin
          s_nxt.rspData = s_r.syncB;
          s_nxt.outGateB = 1'b1;         // [R11]
          s_nxt.tmrStart = 1'b1;
          s_nxt.tmrLoad = tload(FLOAT_CYC);
          s_nxt.st = ST_PG_FLOAT;
        end
      end
      ST_PG_FLOAT: begin
        if (tif.done) begin
          // a wanted one read as zero cannot be repaired
          if (s_r.rspData == s_r.want ||
              (s_r.want & ~s_r.rspData) != '0 ||
              s_r.pulses == MAX_PULSES) begin // [R2] [R3] [R15]
            s_nxt.rspErr = (s_r.rspData != s_r.want);
            s_nxt.rspValid = 1'b1;
            s_nxt.chipSelB = 1'b1;
            s_nxt.vppEn = 1'b0;
            s_nxt.st = ST_IDLE;
          end else begin
            s_nxt.dataOe = 1'b1;         // [R15]
            s_nxt.tmrStart = 1'b1;
            s_nxt.tmrLoad = tload(SETUP_CYC); // [R7]
            s_nxt.st = ST_PG_SETUP;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      s_r <= RST_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign {cmdReady, rspValid, rspData, rspErr, rspPulses} =
    {s_r.cmdReady, s_r.rspValid, s_r.rspData, s_r.rspErr, s_r.pulses};
  assign {memAddr, chipSelB, outGateB, progStrobeB, vppEn} =
    {s_r.memAddr, s_r.chipSelB, s_r.outGateB, s_r.progStrobeB, s_r.vppEn};
  assign {dataPinsOut, dataPinsOe} = {s_r.dataOut, s_r.dataOe};

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [34:0] pinSig, prevSig_r;
  logic prevStrobe_r, prevOe_r;
  opc_cnt_t stableCnt_r, lowCnt_r, riseCnt_r, offCnt_r;

  function automatic opc_cnt_t satInc(input opc_cnt_t c);
    return (c == CNT_SAT) ? c : c + 15'h0001;
  endfunction
  assign pinSig = {s_r.memAddr, s_r.dataOut, s_r.dataOe, s_r.chipSelB,
                   s_r.vppEn};

  always_ff @(posedge clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      prevSig_r <= '0;
      prevStrobe_r <= 1'b1;
      prevOe_r <= 1'b0;
      stableCnt_r <= CNT_SAT;
      lowCnt_r <= '0;
      riseCnt_r <= CNT_SAT;
      offCnt_r <= CNT_SAT;
    end else begin
      prevSig_r <= pinSig;
      prevStrobe_r <= s_r.progStrobeB;
      prevOe_r <= s_r.dataOe;
      stableCnt_r <= (pinSig != prevSig_r) ? 15'h0001 : satInc(stableCnt_r);
      lowCnt_r <= s_r.progStrobeB ? '0 : satInc(lowCnt_r);
      riseCnt_r <= (s_r.progStrobeB && !prevStrobe_r) ? 15'h0001
                   : satInc(riseCnt_r);
      offCnt_r <= (!s_r.dataOe && prevOe_r) ? 15'h0001 : satInc(offCnt_r);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSyncB);
  prog_mode_a: assert property ( // [R4]
    !progStrobeB |-> !chipSelB && vppEn && dataPinsOe)
    else $error("strobe low outside program conditions");
  setup_time_a: assert property ( // [R6] [R7] [R8]
    $fell(progStrobeB) |-> stableCnt_r >= SETUP_CYC)
    else $error("pins not stable 2 us before strobe");
  pulse_width_a: assert property ( // [R18]
    $rose(progStrobeB) |-> lowCnt_r == PULSE_LEN)
    else $error("program pulse width wrong");
  data_hold_a: assert property ( // [R9]
    ($fell(dataPinsOe) || $changed(dataPinsOut)) |->
      riseCnt_r >= HOLD_CYC)
    else $error("write data changed too soon after strobe");
  gate_setup_a: assert property ( // [R10]
    $fell(outGateB) |-> !dataPinsOe && offCnt_r >= OE_SETUP_CYC)
    else $error("gate low too soon after data release");
  addr_hold_a: assert property ( // [R11]
    $changed(memAddr) |-> outGateB && $past(outGateB))
    else $error("address changed while gate low");
  verify_cond_a: assert property ( // [R16]
    (!outGateB && vppEn) |-> progStrobeB && !chipSelB && !dataPinsOe)
    else $error("bad verify pin state");
  pulse_limit_a: assert property ( // [R15]
    $fell(progStrobeB) |-> rspPulses <= MAX_PULSES ##1
      (!progStrobeB)[*8])
    else $error("pulse limit exceeded or pulse too short");
  word_drive_a: assert property ( // [R5]
    $fell(progStrobeB) |-> dataPinsOut == s_r.want)
    else $error("driven word differs from command");
  read_done_c: cover property (rspValid && !vppEn && rspPulses == 8'h00);
  prog_ok_c: cover property ($fell(vppEn) && !rspErr);
  prog_fail_c: cover property ($fell(vppEn) && rspErr);
  retry_c: cover property ($fell(progStrobeB) && rspPulses > 8'h01);
endmodule // opc_otp_host

// ### logic/opc_pkg.sv
package opc_pkg;

  // ---------------------------------------------------------------
  // widths and types
  // ---------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int CNT_W = 15;
  localparam int PCNT_W = 8;

  typedef logic [CNT_W-1:0] opc_cnt_t;
  typedef logic [ADDR_W-1:0] opc_addr_t;
  typedef logic [DATA_W-1:0] opc_data_t;
  typedef logic [PCNT_W-1:0] opc_pcnt_t;

  // ---------------------------------------------------------------
  // timing in printed units
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int SETUP_US = 2;     // addr, data, select, supply to strobe
  localparam int HOLD_US = 2;      // data hold after strobe rises
  localparam int OE_SETUP_US = 2;  // data released to gate low
  localparam int PULSE_US = 100;   // nominal strobe width, 95..105
  localparam int ACC_NS = 200;     // slowest grade address access
  localparam int GATE_ACC_NS = 100; // gate low to data valid, verify
  localparam int FLOAT_NS = 130;   // gate high to pins released
  localparam int SYNC_STAGES = 2;

  // ---------------------------------------------------------------
  // derived cycle counts, least times rounded up
  // ---------------------------------------------------------------
  function automatic opc_cnt_t us2cyc(input int us);
    return opc_cnt_t'(us * CLK_MHZ);
  endfunction

  function automatic opc_cnt_t ns2cyc(input int ns);
    return opc_cnt_t'((ns * CLK_MHZ + 999) / 1000);
  endfunction

  localparam opc_cnt_t SETUP_CYC = us2cyc(SETUP_US);
  localparam opc_cnt_t HOLD_CYC = us2cyc(HOLD_US);
  localparam opc_cnt_t OE_SETUP_CYC = us2cyc(OE_SETUP_US);
  localparam opc_cnt_t ACC_CYC = ns2cyc(ACC_NS);
  localparam opc_cnt_t GATE_CYC = opc_cnt_t'(ns2cyc(GATE_ACC_NS)
                                  + SYNC_STAGES);
  localparam opc_cnt_t FLOAT_CYC = ns2cyc(FLOAT_NS);

  // timer start and done handshake adds this many cycles
  localparam opc_cnt_t TMR_OVH = 15'h0002;
  localparam opc_cnt_t CNT_SAT = 15'h7FFF;
  localparam opc_pcnt_t MAX_PULSES = 8'h19;

endpackage

// ### logic/opc_timer.sv
`timescale 1ns/1ps
module opc_timer import opc_pkg::*; (
  input wire logic clk,      // system clock
  input wire logic rstSyncB, // synchronised reset, active low
  opc_tmr_if.tmr tif         // start, load and done
);

  typedef struct packed {
    opc_cnt_t cnt;
  } opc_tmr_s;

  opc_tmr_s s_r;
  opc_tmr_s s_nxt;

  // ---------------------------------------------------------------
  // down counter, done only when idle and not restarting
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (tif.start) begin
      s_nxt.cnt = tif.load;
    end else if (s_r.cnt != '0) begin
      s_nxt.cnt = s_r.cnt - 15'h0001;
    end
  end

  always_ff @(posedge clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tif.done = (s_r.cnt == '0) && !tif.start;

endmodule // opc_timer

// ### logic/opc_tmr_if.sv
`timescale 1ns/1ps
interface opc_tmr_if;
  import opc_pkg::*;
  logic start;
  opc_cnt_t load;
  logic done;
  modport ctrl (output start, output load, input done);
  modport tmr (input start, input load, output done);
endinterface

// ### tb/opc_otp_host_test.sv
`timescale 1ns/1ps
module opc_otp_host_test import opc_pkg::*;;
  localparam int P_CYC = 50;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cmdValid = 1'b0;
  logic cmdWrite = 1'b0;
  logic [15:0] cmdAddr = 16'h0000;
  logic [15:0] cmdData = 16'h0000;
  logic [7:0] needPulses = 8'h01;
  logic [7:0] gateNs = 8'h0A;
  logic cmdReady, rspValid, rspErr, chipSelB, outGateB, progStrobeB;
  logic vppEn, dataPinsOe;
  logic [7:0] rspPulses;
  logic [15:0] rspData, memAddr, dataPinsIn, dataPinsOut;
  int error_cnt = 0;
  int num_checks = 0;
  int lat;

  always #2.5 clk = ~clk;

  opc_otp_host #(.PULSE_CYC(P_CYC)) uut (.clk(clk), .rst_b(rst_b),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdWrite(cmdWrite),
    .cmdAddr(cmdAddr), .cmdData(cmdData), .rspValid(rspValid),
    .rspData(rspData), .rspErr(rspErr), .rspPulses(rspPulses),
    .memAddr(memAddr), .chipSelB(chipSelB), .outGateB(outGateB),
    .progStrobeB(progStrobeB), .vppEn(vppEn), .dataPinsIn(dataPinsIn),
    .dataPinsOut(dataPinsOut), .dataPinsOe(dataPinsOe));

  opc_otp_model dev (.memAddr(memAddr), .chipSelB(chipSelB),
    .outGateB(outGateB), .progStrobeB(progStrobeB), .vppEn(vppEn),
    .dataPinsOut(dataPinsOut), .dataPinsOe(dataPinsOe),
    .needPulses(needPulses), .gateNs(gateNs), .dataPinsIn(dataPinsIn));

  // ---------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic run_cmd(input logic wr, input logic [15:0] a,
      input logic [15:0] d);
    int n;
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdWrite <= wr;
    cmdAddr <= a;
    cmdData <= d;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cmdReady !== 1'b1 && n < 200);
    @(posedge clk);
    cmdValid <= 1'b0;
    lat = 0;
    do begin
      @(negedge clk);
      lat++;
    end while (rspValid !== 1'b1 && lat < 60000);
    chk(rspValid, 1'b1);
  endtask

  // ---------------------------------------------------------------
  // pin timing monitor
  // ---------------------------------------------------------------
  int cyc = 0, tSet = 0, tFall = 0, tRise = 0, tOff = 0;
  logic pStb = 1'b1, pOe = 1'b0, pGate = 1'b1;
  logic [15:0] pAddr = 16'h0000;
  always @(negedge clk) begin
    cyc++;
    if (chipSelB !== 1'b0 || (pOe !== 1'b1 && dataPinsOe === 1'b1)) begin
      tSet = cyc;
    end
    if (pStb === 1'b1 && progStrobeB === 1'b0) begin
      chk(cyc - tSet >= int'(SETUP_CYC), 1);
      chk({vppEn, dataPinsOe, chipSelB}, 3'h6);
      tFall = cyc;
    end
    if (pStb === 1'b0 && progStrobeB === 1'b1) begin
      chk(cyc - tFall, P_CYC);
      tRise = cyc;
    end
    if (pOe === 1'b1 && dataPinsOe === 1'b0 && vppEn === 1'b1) begin
      chk(cyc - tRise >= int'(HOLD_CYC), 1);
      tOff = cyc;
    end
    if (pGate === 1'b1 && outGateB === 1'b0 && vppEn === 1'b1) begin
      chk(cyc - tOff >= int'(OE_SETUP_CYC), 1);
    end
    if (outGateB === 1'b0) chk(dataPinsOe, 1'b0);
    if (memAddr !== pAddr) chk(outGateB, 1'b1);
    pStb = progStrobeB;
    pOe = dataPinsOe;
    pGate = outGateB;
    pAddr = memAddr;
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    chk({cmdReady, chipSelB, outGateB, progStrobeB}, 4'h7);
    chk({vppEn, dataPinsOe, rspValid}, 3'h0);
    $display("test reset done");
  endtask

  task automatic t_read_erased;
    run_cmd(1'b0, 16'h0012, 16'h0000);
    chk(rspData, 16'hFFFF);
    chk(lat >= 88 && lat <= 90, 1);
    chk({rspErr, rspPulses}, 9'h000);
    $display("test read erased done");
  endtask

  task automatic t_prog_one;
    run_cmd(1'b1, 16'h0012, 16'hA5C3);
    chk({rspErr, rspPulses}, 9'h001);
    chk(rspData, 16'hA5C3);
    run_cmd(1'b0, 16'h0012, 16'h0000);
    chk(rspData, 16'hA5C3);
    $display("test program one done");
  endtask

  task automatic t_no_return;
    run_cmd(1'b1, 16'h0012, 16'hFF00);
    chk({rspErr, rspPulses}, 9'h101);
    chk(rspData, 16'hA500);
    $display("test zero stays done");
  endtask

  task automatic t_multi;
    needPulses <= 8'h03;
    run_cmd(1'b1, 16'hFFFF, 16'h0000);
    chk({rspErr, rspPulses}, 9'h003);
    chk(rspData, 16'h0000);
    $display("test three pulses done");
  endtask

  task automatic t_slow_read;
    gateNs <= 8'h41;
    run_cmd(1'b0, 16'hFFFF, 16'h0000);
    chk(rspData, 16'h0000);
    run_cmd(1'b0, 16'h0000, 16'h0000);
    chk(rspData, 16'hFFFF);
    gateNs <= 8'h0A;
    $display("test slow read done");
  endtask

  task automatic t_exhaust;
    needPulses <= 8'hC8;
    run_cmd(1'b1, 16'h8000, 16'h1234);
    chk({rspErr, rspPulses}, {1'b1, MAX_PULSES});
    chk(rspData, 16'hFFFF);
    $display("test pulse limit done");
  endtask

  initial begin
    repeat (2) @(posedge clk);
    t_reset();
    @(posedge clk);
    rst_b <= 1'b1;
    t_read_erased();
    t_prog_one();
    t_no_return();
    t_multi();
    t_slow_read();
    t_exhaust();
    give_verdict();
  end

  initial begin
    #400000;
    error_cnt++;
    give_verdict();
  end
endmodule // opc_otp_host_test

// ### tb/opc_otp_model.sv
`timescale 1ns/1ps
module opc_otp_model import opc_pkg::*; (
  input wire logic [15:0] memAddr,     // address pins
  input wire logic chipSelB,           // select, active low
  input wire logic outGateB,           // output gate, active low
  input wire logic progStrobeB,        // program strobe, active low
  input wire logic vppEn,              // programming supply raised
  input wire logic [15:0] dataPinsOut, // host drive value
  input wire logic dataPinsOe,         // host drive enable
  input wire logic [7:0] needPulses,   // pulses until cells take
  input wire logic [7:0] gateNs,       // gate low to data valid
  output logic [15:0] dataPinsIn       // resolved pin level
);
  opc_data_t cells [0:65535];
  int pulseCnt [0:65535];
  logic devDrive = 1'b0;
  opc_data_t word;

  initial begin
    foreach (cells[i]) begin
      cells[i] = 16'hFFFF;
      pulseCnt[i] = 0;
    end
  end

  assign word = cells[memAddr];

  // ---------------------------------------------------------------
  // programming: clear bits only, deselected parts ignore strobe
  // ---------------------------------------------------------------
  always @(posedge progStrobeB) begin
    if (chipSelB === 1'b0 && vppEn === 1'b1) begin
      pulseCnt[memAddr] += 1;
      if (pulseCnt[memAddr] >= int'(needPulses)) begin
        cells[memAddr] &= dataPinsIn;
      end
    end
  end

  // ---------------------------------------------------------------
  // read and verify drive
  // ---------------------------------------------------------------
  always @(outGateB or chipSelB) begin
    devDrive = 1'b0;
    if (!outGateB && !chipSelB) begin
      #(gateNs);
      if (!outGateB && !chipSelB && progStrobeB) begin
        devDrive = 1'b1;
      end
    end
  end

  // released pins show a changed level, not the old word
  assign dataPinsIn = dataPinsOe ? dataPinsOut : (devDrive ? word : ~word);
endmodule // opc_otp_model
